// *** rtl/aipc_pkg.sv ***
package aipc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [3:0]  AIPC_OFS_SELECT   = 4'h0;
    localparam logic [3:0]  AIPC_OFS_PINCFG   = 4'h4;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int          AIPC_BIT_NB_NEG   = 15;
    localparam int          AIPC_SB_LSB       = 8;
    localparam int          AIPC_SB_W         = 4;
    localparam int          AIPC_BIT_NA_NEG   = 7;
    localparam int          AIPC_BIT_BG_DIS   = 15;
    localparam int          AIPC_NPINS        = 13;
    localparam logic [15:0] AIPC_SEL_WMASK    = 16'h8f80;
    localparam logic [15:0] AIPC_CFG_WMASK    = 16'h9fff;
    localparam logic [15:0] AIPC_SEL_RESET    = 16'h0000;
    localparam logic [15:0] AIPC_CFG_RESET    = 16'h0000;
    localparam logic [3:0]  AIPC_SB_BANDGAP   = 4'hf;
    localparam logic [1:0]  AIPC_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  AIPC_RESP_SLVERR  = 2'b10;

    // ****************************************************************
    // Converter input routing carrier
    // ****************************************************************
    typedef struct packed {
        logic [3:0] pos_channel;     // Channel code for positive input
        logic       pos_is_bandgap;  // Positive input is the band gap
        logic       neg_is_ain1;     // MUX B negative input is input one
        logic       neg_a_is_ain1;   // MUX A negative input is input one
    } aipc_route_t;

endpackage

// *** rtl/aipc_top.sv ***
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

// What this block does
// - Top pin-config bit high disables band gap reference; low enables it.
// - Pin-config bit set makes pin digital and lets port read return level.
// - Pin-config bit clear makes pin analog, blocks port read, allows sampling.
// - Bits 14-13 are unimplemented, read zero, writes ignored.
module aipc_top
    import aipc_pkg::*;
#(
    parameter int NPINS = AIPC_NPINS
) (
    input  wire logic              aclk,          // System clock
    input  wire logic              aresetn,       // Sync reset, active low
    input  wire logic [3:0]        s_awaddr,      // Write address
    input  wire logic              s_awvalid,     // Write address valid
    output logic                   s_awready,     // Write address ready
    input  wire logic [31:0]       s_wdata,       // Write data
    input  wire logic [3:0]        s_wstrb,       // Write byte strobes
    input  wire logic              s_wvalid,      // Write data valid
    output logic                   s_wready,      // Write data ready
    output logic [1:0]             s_bresp,       // Write response
    output logic                   s_bvalid,      // Write response valid
    input  wire logic              s_bready,      // Write response ready
    input  wire logic [3:0]        s_araddr,      // Read address
    input  wire logic              s_arvalid,     // Read address valid
    output logic                   s_arready,     // Read address ready
    output logic [31:0]            s_rdata,       // Read data
    output logic [1:0]             s_rresp,       // Read response
    output logic                   s_rvalid,      // Read data valid
    input  wire logic              s_rready,      // Read data ready
    input  wire logic [NPINS-1:0]  pin_level,     // Raw pin levels from pads
    output logic [NPINS-1:0]       port_read,     // Levels seen by port read
    output logic [NPINS-1:0]       pin_analog,    // Pin in analog mode
    output logic                   bandgap_en,    // Band gap reference on
    output aipc_route_t            route          // Converter input routing
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [15:0] sel_ff,    nxt_sel;
    logic [15:0] cfg_ff,    nxt_cfg;
    logic        aw_ff,     nxt_aw;
    logic        w_ff,      nxt_w;
    logic [3:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff,  nxt_wdata;
    logic [3:0]  wstrb_ff,  nxt_wstrb;
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff,  nxt_bresp;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff,  nxt_rdata;
    logic [1:0]  rresp_ff,  nxt_rresp;
    logic [15:0] wmerge;
    logic        do_write;

    // Each channel is accepted once and held until the response drains
    assign s_awready = !aw_ff && !bvalid_ff;
    assign s_wready  = !w_ff && !bvalid_ff;
    assign s_arready = !rvalid_ff;
    assign s_bvalid  = bvalid_ff;
    assign s_bresp   = bresp_ff;
    assign s_rvalid  = rvalid_ff;
    assign s_rdata   = rdata_ff;
    assign s_rresp   = rresp_ff;

    always_comb begin
        nxt_aw     = aw_ff;
        nxt_w      = w_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        nxt_sel    = sel_ff;
        nxt_cfg    = cfg_ff;
        wmerge     = 16'h0000;
        if (s_awvalid && s_awready) begin
            nxt_aw     = 1'b1;
            nxt_awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            nxt_w     = 1'b1;
            nxt_wdata = s_wdata;
            nxt_wstrb = s_wstrb;
        end
        do_write = aw_ff && w_ff;
        if (do_write) begin
            nxt_aw     = 1'b0;
            nxt_w      = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = AIPC_RESP_OKAY;
            unique case (awaddr_ff)
                AIPC_OFS_SELECT: begin
                    wmerge[7:0]  = wstrb_ff[0] ? wdata_ff[7:0]  : sel_ff[7:0];
                    wmerge[15:8] = wstrb_ff[1] ? wdata_ff[15:8] : sel_ff[15:8];
                    nxt_sel      = wmerge & AIPC_SEL_WMASK;
                end
                AIPC_OFS_PINCFG: begin
                    wmerge[7:0]  = wstrb_ff[0] ? wdata_ff[7:0]  : cfg_ff[7:0];
                    wmerge[15:8] = wstrb_ff[1] ? wdata_ff[15:8] : cfg_ff[15:8];
                    nxt_cfg      = wmerge & AIPC_CFG_WMASK;
                end
                default: nxt_bresp = AIPC_RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && s_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = AIPC_RESP_OKAY;
            unique case (s_araddr)
                AIPC_OFS_SELECT: nxt_rdata = {16'h0000, sel_ff};
                AIPC_OFS_PINCFG: nxt_rdata = {16'h0000, cfg_ff};
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = AIPC_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff    <= AIPC_SEL_RESET;
            cfg_ff    <= AIPC_CFG_RESET;
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'b00;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'b00;
        end else begin
            sel_ff    <= nxt_sel;
            cfg_ff    <= nxt_cfg;
            aw_ff     <= nxt_aw;
            w_ff      <= nxt_w;
            awaddr_ff <= nxt_awaddr;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // ****************************************************************
    // Pin and converter outputs
    // ****************************************************************
    // Analog pins read as zero so a floating analog level never toggles logic
    assign port_read  = pin_level & cfg_ff[NPINS-1:0];
    assign pin_analog = ~cfg_ff[NPINS-1:0];
    assign bandgap_en = ~cfg_ff[AIPC_BIT_BG_DIS];

    // Absent channels on the small package are not screened here
    always_comb begin
        route.pos_channel    = sel_ff[AIPC_SB_LSB +: AIPC_SB_W];
        route.pos_is_bandgap = (sel_ff[AIPC_SB_LSB +: AIPC_SB_W] == AIPC_SB_BANDGAP);
        route.neg_is_ain1    = sel_ff[AIPC_BIT_NB_NEG];
        route.neg_a_is_ain1  = sel_ff[AIPC_BIT_NA_NEG];
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_cfg_write;
        aw_ff && w_ff && awaddr_ff == AIPC_OFS_PINCFG && wstrb_ff[1];
    endsequence

    a_bandgap_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        s_cfg_write |=> bandgap_en == !$past(wdata_ff[15]))
        else $error("band gap enable does not follow written bit");

    a_digital_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (port_read & ~cfg_ff[NPINS-1:0]) == '0 && (port_read | ~cfg_ff[NPINS-1:0]) ==
        (pin_level | ~cfg_ff[NPINS-1:0]))
        else $error("port read does not match digital pins");

    a_analog_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_analog == ~cfg_ff[NPINS-1:0] && (port_read & pin_analog) == '0)
        else $error("analog pin not blocked");

    a_gap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rvalid && $past(s_araddr == AIPC_OFS_PINCFG && s_arvalid && s_arready)
        |-> s_rdata[14:13] == 2'b00)
        else $error("unimplemented bits read nonzero");

    a_route_code: assert property (@(posedge aclk) disable iff (!aresetn)
        route.pos_is_bandgap == (route.pos_channel == 4'hf) &&
        route.neg_is_ain1 == sel_ff[15])
        else $error("converter routing mismatch");

    a_bresp_once: assert property (@(posedge aclk) disable iff (!aresetn)
        (aw_ff && w_ff) |=> s_bvalid)
        else $error("write response missing");

    // Reads answer one edge after the address is taken, never later
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_arvalid && s_arready |=> s_rvalid)
        else $error("read response missing");

    a_write_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid |-> !s_awready && !s_wready)
        else $error("write channel open while response pending");

endmodule // aipc_top

// *** testbench/adc_input_pin_config_test.sv ***
`timescale 1ns/1ps
module adc_input_pin_config_test;
    import aipc_pkg::*;
    typedef struct packed {logic [3:0] a; logic [31:0] d; logic [15:0] e;} aipc_row_t;
    logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, bandgap_en;
    logic [3:0]  s_awaddr, s_araddr, s_wstrb;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [1:0]  s_bresp, s_rresp, resp;
    logic [12:0] pin_level, port_read, pin_analog;
    logic [15:0] cfg, sel;
    logic [3:0]  wstrb_use = 4'hf;
    aipc_route_t route;
    int          fail_count = 0, checks = 0, cycles = 0;
    // Unimplemented bits written as ones must read back as zero
    aipc_row_t   rows [7] = '{'{AIPC_OFS_PINCFG, 32'hffffffff, 16'h9fff},
        '{AIPC_OFS_PINCFG, 32'h00006000, 16'h0000}, '{AIPC_OFS_PINCFG, 32'h00008000, 16'h8000},
        '{AIPC_OFS_PINCFG, 32'h00001555, 16'h1555}, '{AIPC_OFS_SELECT, 32'h0000ffff, 16'h8f80},
        '{AIPC_OFS_SELECT, 32'h00000f00, 16'h0f00}, '{AIPC_OFS_SELECT, 32'h00008380, 16'h8380}};
    aipc_top #(.NPINS(13)) i_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pin_level, .port_read,
        .pin_analog, .bandgap_en, .route);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Handshakes are judged from registered state just after an edge; valids are
    // released right after the edge that takes them, response readies stay high
    task axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wvalid <= 1'b1;
        s_wstrb <= wstrb_use; s_bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            #1;
            ah = s_awvalid && s_awready; wh = s_wvalid && s_wready; bh = s_bvalid && s_bready;
            r = s_bresp;
            @(posedge aclk);
            if (ah) s_awvalid <= 1'b0;
            if (wh) s_wvalid <= 1'b0;
        end
    endtask
    task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, rh;
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        rh = 1'b0;
        while (!rh) begin
            #1;
            ah = s_arvalid && s_arready; rh = s_rvalid && s_rready; d = s_rdata; r = s_rresp;
            @(posedge aclk);
            if (ah) s_arvalid <= 1'b0;
        end
    endtask
    task rd_chk(input logic [3:0] a, input logic [15:0] e);
        axi_read(a, rd, resp);
        chk("rresp", AIPC_RESP_OKAY, resp);
        chk("rdata", e, rd);
    endtask
    task check_outputs();
        #1;
        chk("bandgap_en", cfg[15] ^ 1'b1, bandgap_en);
        chk("pin_analog", cfg[12:0] ^ 13'h1fff, pin_analog);
        chk("port_read", pin_level & cfg[12:0], port_read);
        chk("pos_channel", sel[11:8], route.pos_channel);
        chk("pos_is_bandgap", sel[11:8] == 4'hf, route.pos_is_bandgap);
        chk("neg_is_ain1", sel[15], route.neg_is_ain1);
        chk("neg_a_is_ain1", sel[7], route.neg_a_is_ain1);
        @(posedge aclk);
    endtask
    initial begin
        aresetn = 1'b0; s_awvalid = 1'b0; s_wvalid = 1'b0; s_bready = 1'b0; s_arvalid = 1'b0;
        s_rready = 1'b0; s_awaddr = 4'h0; s_araddr = 4'h0; s_wdata = 32'h0; s_wstrb = 4'h0;
        pin_level = 13'h0f0f; cfg = 16'h0000; sel = 16'h0000;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        check_outputs();
        rd_chk(AIPC_OFS_PINCFG, 16'h0000);
        rd_chk(AIPC_OFS_SELECT, 16'h0000);
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].d, resp);
            chk("bresp", AIPC_RESP_OKAY, resp);
            if (rows[i].a == AIPC_OFS_PINCFG) cfg = rows[i].e;
            else sel = rows[i].e;
            check_outputs();
            rd_chk(rows[i].a, rows[i].e);
        end
        for (int c = 0; c < 16; c++) begin
            sel = {8'h80, 8'h00} | (16'(c) << 8);
            axi_write(AIPC_OFS_SELECT, {16'h0, sel}, resp);
            check_outputs();
        end
        // Small-package software: absent channels kept digital, never selected
        cfg = 16'h01c0; sel = 16'h0500;
        axi_write(AIPC_OFS_PINCFG, {16'h0, cfg}, resp);
        axi_write(AIPC_OFS_SELECT, {16'h0, sel}, resp);
        check_outputs();
        // Low byte strobe only: the upper byte must keep its old contents
        wstrb_use = 4'h1;
        cfg = 16'h013c;
        axi_write(AIPC_OFS_PINCFG, 32'h0000ff3c, resp);
        wstrb_use = 4'hf;
        check_outputs();
        rd_chk(AIPC_OFS_PINCFG, cfg);
        // Unmapped word must be refused and leave both registers alone
        axi_write(4'h8, 32'h0000ffff, resp);
        chk("bresp_unmapped", AIPC_RESP_SLVERR, resp);
        axi_read(4'h8, rd, resp);
        chk("rresp_unmapped", AIPC_RESP_SLVERR, resp);
        chk("rdata_unmapped", 32'h0, rd);
        pin_level <= 13'h10f0;
        @(posedge aclk);
        check_outputs();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cfg = 16'h0000; sel = 16'h0000;
        check_outputs();
        rd_chk(AIPC_OFS_PINCFG, 16'h0000);
        conclude();
    end
endmodule // adc_input_pin_config_test
